// ### design/charge_timer.sv
// Battery charge timer: modes, indication, POR handshake, scan, AHB-Lite
`timescale 1ns/1ps
module charge_timer #(
	parameter int DEBOUNCE_CYCLES = charge_timer_pkg::DEBOUNCE_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic supplyRampUp,
	input wire logic mainsSenseIn,
	input wire logic dischargeRequestN,
	input wire logic chargeTick,
	input wire logic dischargeTick,
	input wire logic selfTick,
	input wire logic scanSelect,
	input wire logic scanClkIn,
	input wire logic scanSerialIn,
	output logic ledOut,
	output logic loadSwitchOn,
	output logic lowBattScanSharedOut,
	output logic irq
);

	localparam int DB_WIDTH = $clog2(DEBOUNCE_CYCLES + 1);
	localparam logic [DB_WIDTH-1:0] DB_LAST = DB_WIDTH'(DEBOUNCE_CYCLES - 1);
	localparam int EW = charge_timer_pkg::EVT_WIDTH;

	// ****************************************************************
	// Power-on request handshake
	// ****************************************************************
	logic porReq_q, porReq_d, porSync_q, porSync_d, porAck_q, porAck_d;

	always_comb
	begin
		// A new ramp wins over an acknowledge in the same cycle
		porReq_d = supplyRampUp | (porReq_q & ~porAck_q);
		porSync_d = porReq_q;
		porAck_d = porSync_q;
	end

	// Request starts set: the flops come up in power-on state
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			porReq_q <= 1'b1;
			porSync_q <= 1'b0;
			porAck_q <= 1'b0;
		end
		else
		begin
			porReq_q <= porReq_d;
			porSync_q <= porSync_d;
			porAck_q <= porAck_d;
		end
	end

	// ****************************************************************
	// Discharge request debounce
	// ****************************************************************
	logic disStable_q, disStable_d, disFall;
	logic [DB_WIDTH-1:0] dbCnt_q, dbCnt_d;

	always_comb
	begin
		disStable_d = disStable_q;
		dbCnt_d = '0;
		if (dischargeRequestN != disStable_q)
		begin
			if (dbCnt_q == DB_LAST)
				disStable_d = dischargeRequestN;
			else
				dbCnt_d = dbCnt_q + 1'b1;
		end
		disFall = disStable_q & ~disStable_d;
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			disStable_q <= 1'b1;
			dbCnt_q <= '0;
		end
		else
		begin
			disStable_q <= disStable_d;
			dbCnt_q <= dbCnt_d;
		end
	end

	// ****************************************************************
	// Timer, indication and scan chain
	// ****************************************************************
	charge_timer_pkg::state_type state_q, state_d;
	logic [9:0] cnt_q, cnt_d, cntPerm;
	logic [16:0] div_q, div_d, divMask;
	logic [7:0] ledDiv_q, ledDiv_d;
	logic [5:0] pulseCnt_q, pulseCnt_d;
	logic [7:0] aux_q, aux_d;
	logic led_q, led_d, sharedOut_q, sharedOut_d, load_q, load_d;
	logic scanClkPrev_q, scanEdge, tick, divWrap, ledSel_q;
	logic [48:0] chain, chainNext;
	logic [EW-1:0] evt;

	always_comb
	begin
		state_d = state_q;
		cnt_d = cnt_q;
		div_d = div_q;
		ledDiv_d = ledDiv_q;
		pulseCnt_d = pulseCnt_q;
		aux_d = aux_q;
		led_d = led_q;
		evt = '0;
		scanEdge = scanClkIn & ~scanClkPrev_q;
		// Output end first: MSB, aux, pulse, LED, divider, bits 1..8, LSB.
		// The output flop mirrors the end bit, so a loopback closes a
		// ring of exactly 49 places and 49 pulses restore the state.
		chain = {cnt_q[0], cnt_q[8:1], div_q, ledDiv_q, pulseCnt_q, aux_q,
			cnt_q[9]};
		chainNext = {scanSerialIn, chain[48:1]};
		cntPerm = {chainNext[0], chainNext[47:40], chainNext[48]};
		case (state_q)
			charge_timer_pkg::ST_CHARGE,
			charge_timer_pkg::ST_TRICKLE:
			begin
				tick = chargeTick;
				divMask = charge_timer_pkg::CHARGE_DIV_MASK;
			end
			charge_timer_pkg::ST_DISCH:
			begin
				tick = dischargeTick;
				divMask = charge_timer_pkg::DISCH_DIV_MASK;
			end
			default:
			begin
				tick = selfTick;
				divMask = charge_timer_pkg::SELF_DIV_MASK;
			end
		endcase
		divWrap = tick && ((div_q & divMask) == divMask);
		if (porSync_q)
		begin
			state_d = charge_timer_pkg::ST_CHARGE;
			cnt_d = '0;
			div_d = '0;
			ledDiv_d = '0;
			pulseCnt_d = '0;
			aux_d = '0;
			led_d = 1'b0;
		end
		else if (scanSelect)
		begin
			// Normal operation is frozen while the chain is read
			if (scanEdge)
			begin
				cnt_d = cntPerm;
				div_d = chainNext[39:23];
				ledDiv_d = chainNext[22:15];
				pulseCnt_d = chainNext[14:9];
				aux_d = chainNext[8:1];
			end
		end
		else if (disFall && state_q != charge_timer_pkg::ST_DISCH
			&& state_q != charge_timer_pkg::ST_ALARM)
		begin
			state_d = charge_timer_pkg::ST_DISCH;
			div_d = '0;
			evt[charge_timer_pkg::EVT_DISCHARGE_BIT] = 1'b1;
		end
		else
		begin
			if (tick)
				div_d = divWrap ? '0 : div_q + 1'b1;
			case (state_q)
				charge_timer_pkg::ST_CHARGE:
				begin
					if (!mainsSenseIn)
						state_d = charge_timer_pkg::ST_SELF;
					else if (divWrap && cnt_q == '1)
					begin
						state_d = charge_timer_pkg::ST_TRICKLE;
						evt[charge_timer_pkg::EVT_TRICKLE_BIT] = 1'b1;
					end
					else if (divWrap)
						cnt_d = cnt_q + 1'b1;
					if (!ledSel_q)
						led_d = 1'b0;
					else if (chargeTick)
					begin
						ledDiv_d = ledDiv_q + 1'b1;
						if (ledDiv_d == charge_timer_pkg::LED_CHARGE_HALF)
						begin
							led_d = ~led_q;
							ledDiv_d = '0;
						end
					end
				end
				charge_timer_pkg::ST_TRICKLE:
				begin
					if (!mainsSenseIn)
						state_d = charge_timer_pkg::ST_SELF;
					// On phase counts charge ticks, off phase counts self ticks
					if ((led_q && chargeTick) || (!led_q && selfTick))
					begin
						ledDiv_d = ledDiv_q + 1'b1;
						if (ledDiv_d == (led_q ? charge_timer_pkg::TRICKLE_ON_TICKS
							: charge_timer_pkg::TRICKLE_OFF_TICKS))
						begin
							led_d = ~led_q;
							ledDiv_d = '0;
						end
					end
				end
				charge_timer_pkg::ST_DISCH:
				begin
					if (divWrap && cnt_q <= 10'h001)
					begin
						state_d = charge_timer_pkg::ST_ALARM;
						cnt_d = '0;
						evt[charge_timer_pkg::EVT_BATT_LOW_BIT] = 1'b1;
					end
					else if (divWrap)
						cnt_d = cnt_q - 1'b1;
					if (!ledSel_q)
						led_d = 1'b0;
					else if (dischargeTick)
					begin
						ledDiv_d = ledDiv_q + 1'b1;
						if (ledDiv_d == charge_timer_pkg::LED_ALARM_HALF)
						begin
							led_d = ~led_q;
							ledDiv_d = '0;
						end
					end
				end
				charge_timer_pkg::ST_SELF:
				begin
					// An empty counter idles here without a new alarm
					if (mainsSenseIn)
						state_d = charge_timer_pkg::ST_CHARGE;
					else if (divWrap && cnt_q != '0)
					begin
						cnt_d = cnt_q - 1'b1;
						if (cnt_q == 10'h001)
						begin
							state_d = charge_timer_pkg::ST_ALARM;
							evt[charge_timer_pkg::EVT_BATT_LOW_BIT] = 1'b1;
						end
					end
				end
				charge_timer_pkg::ST_ALARM:
				begin
					if (selfTick)
					begin
						pulseCnt_d = pulseCnt_q + 1'b1;
						if (pulseCnt_q == '1)
							state_d = charge_timer_pkg::ST_SELF;
					end
				end
				default:
					state_d = charge_timer_pkg::ST_CHARGE;
			endcase
			if (state_d != state_q)
			begin
				ledDiv_d = '0;
				led_d = (state_d == charge_timer_pkg::ST_TRICKLE);
				div_d = '0;
			end
		end
		if (scanSelect)
			sharedOut_d = scanEdge ? chainNext[0] : chain[0];
		else
			sharedOut_d = (state_q == charge_timer_pkg::ST_ALARM)
				&& !pulseCnt_q[charge_timer_pkg::PULSE_HALF_BIT];
		load_d = (state_d == charge_timer_pkg::ST_CHARGE)
			|| (state_d == charge_timer_pkg::ST_TRICKLE && led_d);
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= charge_timer_pkg::ST_CHARGE;
			cnt_q <= '0;
			div_q <= '0;
			ledDiv_q <= '0;
			pulseCnt_q <= '0;
			aux_q <= '0;
			led_q <= 1'b0;
			sharedOut_q <= 1'b0;
			load_q <= 1'b0;
			scanClkPrev_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			div_q <= div_d;
			ledDiv_q <= ledDiv_d;
			pulseCnt_q <= pulseCnt_d;
			aux_q <= aux_d;
			led_q <= led_d;
			sharedOut_q <= sharedOut_d;
			load_q <= load_d;
			scanClkPrev_q <= scanClkIn;
		end
	end

	assign ledOut = led_q;
	assign loadSwitchOn = load_q;
	assign lowBattScanSharedOut = sharedOut_q;

	// ****************************************************************
	// AHB-Lite slave and interrupts
	// ****************************************************************
	logic addrPhase, wrPend_q, wrPend_d, ledSel_d, irq_q, irq_d;
	logic [7:0] addr_q, addr_d;
	logic [31:0] rdata_q, rdata_d;
	logic [EW-1:0] intSt_q, intSt_d, intMask_q, intMask_d, clr;

	always_comb
	begin
		addrPhase = hsel && hready && htrans[1];
		wrPend_d = addrPhase && hwrite;
		addr_d = addrPhase ? haddr[7:0] : addr_q;
		ledSel_d = ledSel_q;
		intMask_d = intMask_q;
		clr = '0;
		if (wrPend_q)
		begin
			case (addr_q)
				charge_timer_pkg::CTRL_OFFSET:
					ledSel_d = hwdata[charge_timer_pkg::CTRL_LED_SEL_BIT];
				charge_timer_pkg::INT_STATUS_OFFSET:
					clr = hwdata[EW-1:0];
				charge_timer_pkg::INT_MASK_OFFSET:
					intMask_d = hwdata[EW-1:0];
				default:
					clr = '0;
			endcase
		end
		// A new event wins over a clear in the same cycle
		intSt_d = (intSt_q & ~clr) | evt;
		irq_d = |(intSt_d & intMask_d);
		rdata_d = '0;
		if (addrPhase && !hwrite)
		begin
			case (haddr[7:0])
				charge_timer_pkg::CTRL_OFFSET:
					rdata_d[charge_timer_pkg::CTRL_LED_SEL_BIT] = ledSel_q;
				charge_timer_pkg::STATUS_OFFSET:
				begin
					rdata_d[charge_timer_pkg::STATUS_STATE_LSB +: 5] = state_q;
					rdata_d[charge_timer_pkg::STATUS_POR_BIT] = porReq_q;
					rdata_d[charge_timer_pkg::STATUS_SCAN_BIT] = scanSelect;
					rdata_d[charge_timer_pkg::STATUS_LED_BIT] = led_q;
					rdata_d[charge_timer_pkg::STATUS_COUNT_LSB +: 10] = cnt_q;
				end
				charge_timer_pkg::INT_STATUS_OFFSET:
					rdata_d[EW-1:0] = intSt_q;
				charge_timer_pkg::INT_MASK_OFFSET:
					rdata_d[EW-1:0] = intMask_q;
				default:
					rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wrPend_q <= 1'b0;
			addr_q <= '0;
			rdata_q <= '0;
			ledSel_q <= charge_timer_pkg::CTRL_LED_SEL_RESET;
			intSt_q <= '0;
			intMask_q <= charge_timer_pkg::INT_MASK_RESET;
			irq_q <= 1'b0;
		end
		else
		begin
			wrPend_q <= wrPend_d;
			addr_q <= addr_d;
			rdata_q <= rdata_d;
			ledSel_q <= ledSel_d;
			intSt_q <= intSt_d;
			intMask_q <= intMask_d;
			irq_q <= irq_d;
		end
	end

	assign hrdata = rdata_q;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign irq = irq_q;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	a_por_sync_stage: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(porReq_q) |=> porSync_q && !porAck_q)
		else $error("power-on request not synchronised");
	a_por_ack_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
		porSync_q && !supplyRampUp |=> porAck_q ##1 !porReq_q)
		else $error("power-on request not acknowledged");
	a_por_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
		(porReq_q && !porAck_q) || supplyRampUp |=> porReq_q)
		else $error("power-on request dropped early");
	a_por_start: assert property (@(posedge core_clk) disable iff (!rst_n)
		porSync_q |=> state_q == charge_timer_pkg::ST_CHARGE && cnt_q == '0)
		else $error("no fresh charge start after power-on");
	a_dis_start: assert property (@(posedge core_clk) disable iff (!rst_n)
		disFall && !porSync_q && !scanSelect
		&& state_q == charge_timer_pkg::ST_CHARGE
		|=> state_q == charge_timer_pkg::ST_DISCH)
		else $error("discharge request ignored");
	a_debounce_len: assert property (@(posedge core_clk) disable iff (!rst_n)
		$changed(disStable_q) |-> $past(dbCnt_q) == DB_LAST)
		else $error("debounce accepted early");
	a_scan_freeze: assert property (@(posedge core_clk) disable iff (!rst_n)
		scanSelect && !scanEdge && !porSync_q |=> $stable(cnt_q)
		&& $stable(state_q))
		else $error("state changed while scanning");
	a_scan_shift: assert property (@(posedge core_clk) disable iff (!rst_n)
		scanSelect && scanEdge |=> sharedOut_q == $past(chainNext[0]))
		else $error("scan output did not advance");
	a_scan_input: assert property (@(posedge core_clk) disable iff (!rst_n)
		scanSelect && scanEdge && !porSync_q |=> cnt_q[0] == $past(scanSerialIn))
		else $error("scan input not at counter LSB");
	a_low_pulses: assert property (@(posedge core_clk) disable iff (!rst_n)
		!scanSelect && state_q == charge_timer_pkg::ST_ALARM
		|=> sharedOut_q == !$past(pulseCnt_q[3]))
		else $error("battery-low pulse level wrong");
	a_trickle_switch: assert property (@(posedge core_clk) disable iff (!rst_n)
		state_q == charge_timer_pkg::ST_CHARGE && divWrap && cnt_q == '1
		&& mainsSenseIn && !scanSelect && !porSync_q && !disFall
		|=> state_q == charge_timer_pkg::ST_TRICKLE && led_q)
		else $error("no switch to trickle charge");
	a_led_charge: assert property (@(posedge core_clk) disable iff (!rst_n)
		state_q == charge_timer_pkg::ST_CHARGE && ledSel_q && chargeTick
		&& ledDiv_q == 8'h7F && mainsSenseIn && !divWrap && !scanSelect
		&& !porSync_q && !disFall |=> led_q != $past(led_q))
		else $error("charge blink rate wrong");

endmodule

// ### design/charge_timer_pkg.sv
// Constants, register map and state encoding of the charge timer
package charge_timer_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;
	localparam logic [7:0] INT_STATUS_OFFSET = 8'h08;
	localparam logic [7:0] INT_MASK_OFFSET = 8'h0C;
	localparam int CTRL_LED_SEL_BIT = 0;
	localparam logic CTRL_LED_SEL_RESET = 1'b1;
	localparam int STATUS_STATE_LSB = 0;
	localparam int STATUS_POR_BIT = 5;
	localparam int STATUS_SCAN_BIT = 6;
	localparam int STATUS_LED_BIT = 7;
	localparam int STATUS_COUNT_LSB = 16;
	localparam int EVT_WIDTH = 3;
	localparam int EVT_TRICKLE_BIT = 0;
	localparam int EVT_BATT_LOW_BIT = 1;
	localparam int EVT_DISCHARGE_BIT = 2;
	localparam logic [2:0] INT_MASK_RESET = 3'h0;

	// ****************************************************************
	// Timer structure
	// ****************************************************************
	localparam int COUNT_WIDTH = 10;
	localparam int DIV_WIDTH = 17;
	localparam logic [16:0] CHARGE_DIV_MASK = 17'h0_0FFF;
	localparam logic [16:0] DISCH_DIV_MASK = 17'h0_00FF;
	localparam logic [16:0] SELF_DIV_MASK = 17'h1_FFFF;
	localparam int LED_DIV_WIDTH = 8;
	localparam logic [7:0] LED_CHARGE_HALF = 8'h80;
	localparam logic [7:0] LED_ALARM_HALF = 8'h10;
	localparam logic [7:0] TRICKLE_ON_TICKS = 8'h08;
	localparam logic [7:0] TRICKLE_OFF_TICKS = 8'h06;
	localparam int PULSE_WIDTH = 6;
	localparam int PULSE_HALF_BIT = 3;
	localparam int SCAN_LEN = 49;
	localparam int AUX_WIDTH = 8;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_HZ = 20_000_000;
	localparam int DEBOUNCE_MS = 10;
	localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * (CLK_HZ / 1000);

	typedef enum logic [4:0] {
		ST_CHARGE = 5'b0_0001,
		ST_TRICKLE = 5'b0_0010,
		ST_DISCH = 5'b0_0100,
		ST_SELF = 5'b0_1000,
		ST_ALARM = 5'b1_0000
	} state_type;

endpackage

// ### verif/charger_far_side.sv
// Far-side model: oscillator ticks, discharge switch and scan reader
`timescale 1ns/1ps
module charger_far_side (
	input wire logic core_clk,
	input wire logic lowBattScanSharedOut,
	output logic chargeTick,
	output logic dischargeTick,
	output logic selfTick,
	output logic mainsSenseIn,
	output logic dischargeRequestN,
	output logic scanSelect,
	output logic scanClkIn,
	output logic scanSerialIn
);
	// Loopback keeps the chain contents intact across a read-out
	assign scanSerialIn = lowBattScanSharedOut;

	initial
	begin
		chargeTick = 1'b0;
		dischargeTick = 1'b0;
		selfTick = 1'b0;
		mainsSenseIn = 1'b1;
		// Open switch: the pull-up holds the request line high
		dischargeRequestN = 1'b1;
		scanSelect = 1'b0;
		scanClkIn = 1'b0;
	end

	// One tick per oscillator period, kind 0 charge, 1 discharge, 2 self
	task automatic runTicks(input int kind, input int n);
		repeat (n)
		begin
			@(posedge core_clk);
			chargeTick <= (kind == 0);
			dischargeTick <= (kind == 1);
			selfTick <= (kind == 2);
			@(posedge core_clk);
			chargeTick <= 1'b0;
			dischargeTick <= 1'b0;
			selfTick <= 1'b0;
		end
	endtask

	task automatic setSwitch(input logic level, input int cycles);
		@(posedge core_clk);
		dischargeRequestN <= level;
		repeat (cycles) @(posedge core_clk);
	endtask

	task automatic setMains(input logic level);
		@(posedge core_clk);
		mainsSenseIn <= level;
	endtask

	// Scan select is raised only for the read-out, then dropped
	task automatic setScan(input logic level);
		@(posedge core_clk);
		scanSelect <= level;
		repeat (2) @(posedge core_clk);
	endtask

	// The scan clock stands still outside a read-out
	task automatic scanRead(output logic [48:0] bits);
		for (int i = 0; i < 49; i++)
		begin
			@(posedge core_clk);
			scanClkIn <= 1'b1;
			repeat (2) @(posedge core_clk);
			scanClkIn <= 1'b0;
			repeat (2) @(posedge core_clk);
			bits[i] = lowBattScanSharedOut;
		end
	endtask
endmodule

// ### verif/test_battery_charge_timer_indication.sv
// Self-checking bench for the battery charge timer
`timescale 1ns/1ps
module test_battery_charge_timer_indication;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic supplyRampUp = 1'b0;
	logic hready, hresp, irq, ledOut, loadSwitchOn, lowBattScanSharedOut;
	logic [31:0] hrdata;
	logic chargeTick, dischargeTick, selfTick, mainsSenseIn;
	logic dischargeRequestN, scanSelect, scanClkIn, scanSerialIn;
	int numErrors = 0;
	int comparisons = 0;

	// Single slave: its ready is the bus ready
	charge_timer #(.DEBOUNCE_CYCLES(20)) dut (.core_clk(core_clk),
		.rst_n(rst_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hready(hready), .hwdata(hwdata),
		.hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
		.supplyRampUp(supplyRampUp), .mainsSenseIn(mainsSenseIn),
		.dischargeRequestN(dischargeRequestN), .chargeTick(chargeTick),
		.dischargeTick(dischargeTick), .selfTick(selfTick),
		.scanSelect(scanSelect), .scanClkIn(scanClkIn),
		.scanSerialIn(scanSerialIn), .ledOut(ledOut),
		.loadSwitchOn(loadSwitchOn),
		.lowBattScanSharedOut(lowBattScanSharedOut), .irq(irq));

	charger_far_side far (.core_clk(core_clk),
		.lowBattScanSharedOut(lowBattScanSharedOut),
		.chargeTick(chargeTick), .dischargeTick(dischargeTick),
		.selfTick(selfTick), .mainsSenseIn(mainsSenseIn),
		.dischargeRequestN(dischargeRequestN), .scanSelect(scanSelect),
		.scanClkIn(scanClkIn), .scanSerialIn(scanSerialIn));

	always #25 core_clk = ~core_clk;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			numErrors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One AHB-Lite single transfer; waits for ready with no cycle limit
	task automatic busXfer(input logic wr, input logic [7:0] addr,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge core_clk);
		haddr <= {24'h00_0000, addr};
		htrans <= 2'h2;
		hwrite <= wr;
		do
			@(posedge core_clk);
		while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do
			@(posedge core_clk);
		while (hready !== 1'b1);
		rd = hrdata;
	endtask

	task automatic testResetValues();
		logic [31:0] rd;
		busXfer(1'b0, charge_timer_pkg::STATUS_OFFSET, 32'h0, rd);
		check(32'(rd[4:0]), 32'(charge_timer_pkg::ST_CHARGE));
		check(32'(rd[5]), 32'h0000_0000);
		check(32'(rd[25:16]), 32'h0000_0000);
		check(32'(loadSwitchOn), 32'h0000_0001);
		busXfer(1'b0, charge_timer_pkg::CTRL_OFFSET, 32'h0, rd);
		check(rd, 32'h0000_0001);
		busXfer(1'b0, charge_timer_pkg::INT_MASK_OFFSET, 32'h0, rd);
		check(rd, 32'h0000_0000);
		busXfer(1'b0, 8'h10, 32'h0, rd);
		check(rd, 32'h0000_0000);
	endtask

	// Charge blink toggles every 128 ticks; 4096 ticks step the counter
	task automatic testChargeLed();
		logic [31:0] rd;
		far.runTicks(0, 127);
		repeat (3) @(posedge core_clk);
		check(32'(ledOut), 32'h0000_0000);
		far.runTicks(0, 1);
		repeat (3) @(posedge core_clk);
		check(32'(ledOut), 32'h0000_0001);
		far.runTicks(0, 3968);
		repeat (3) @(posedge core_clk);
		busXfer(1'b0, charge_timer_pkg::STATUS_OFFSET, 32'h0, rd);
		check(32'(rd[25:16]), 32'h0000_0001);
	endtask

	// Counter holds 1: LSB after pulse 48, MSB after pulse 49
	task automatic testScanReadout();
		logic [48:0] bits;
		logic [31:0] rd;
		far.setScan(1'b1);
		far.scanRead(bits);
		check(32'({bits[48], bits[46:39], bits[47]}), 32'h0000_0001);
		busXfer(1'b0, charge_timer_pkg::STATUS_OFFSET, 32'h0, rd);
		check(32'(rd[6]), 32'h0000_0001);
		far.setScan(1'b0);
		busXfer(1'b0, charge_timer_pkg::STATUS_OFFSET, 32'h0, rd);
		check(32'(rd[25:16]), 32'h0000_0001);
		check(32'(rd[6]), 32'h0000_0000);
	endtask

	// Bursts shorter than the debounce span are ignored
	task automatic testDischargeRequest();
		logic [31:0] rd;
		far.setSwitch(1'b0, 10);
		far.setSwitch(1'b1, 5);
		far.setSwitch(1'b0, 10);
		far.setSwitch(1'b1, 5);
		busXfer(1'b0, charge_timer_pkg::STATUS_OFFSET, 32'h0, rd);
		check(32'(rd[4:0]), 32'(charge_timer_pkg::ST_CHARGE));
		far.setSwitch(1'b0, 30);
		far.setSwitch(1'b1, 2);
		busXfer(1'b0, charge_timer_pkg::STATUS_OFFSET, 32'h0, rd);
		check(32'(rd[4:0]), 32'(charge_timer_pkg::ST_DISCH));
		check(32'(loadSwitchOn), 32'h0000_0000);
		check(32'(irq), 32'h0000_0000);
		busXfer(1'b1, charge_timer_pkg::INT_MASK_OFFSET, 32'h0000_0004, rd);
		repeat (2) @(posedge core_clk);
		check(32'(irq), 32'h0000_0001);
		busXfer(1'b1, charge_timer_pkg::INT_STATUS_OFFSET, 32'h0000_0004, rd);
		repeat (2) @(posedge core_clk);
		check(32'(irq), 32'h0000_0000);
		busXfer(1'b0, charge_timer_pkg::INT_STATUS_OFFSET, 32'h0, rd);
		check(rd, 32'h0000_0000);
	endtask

	// Empty counter raises the alarm: four 16-tick periods, half high
	task automatic testAlarmPulses();
		logic [31:0] rd;
		int highs;
		// Mains absent, so the timer stays in self-discharge after the alarm
		far.setMains(1'b0);
		busXfer(1'b1, charge_timer_pkg::INT_MASK_OFFSET, 32'h0000_0002, rd);
		far.runTicks(1, 16);
		repeat (2) @(posedge core_clk);
		check(32'(ledOut), 32'h0000_0001);
		far.runTicks(1, 240);
		repeat (3) @(posedge core_clk);
		busXfer(1'b0, charge_timer_pkg::STATUS_OFFSET, 32'h0, rd);
		check(32'(rd[4:0]), 32'(charge_timer_pkg::ST_ALARM));
		highs = 0;
		for (int i = 0; i < 80; i++)
		begin
			far.runTicks(2, 1);
			@(negedge core_clk);
			highs += (lowBattScanSharedOut === 1'b1);
		end
		check(32'(highs), 32'd32);
		busXfer(1'b0, charge_timer_pkg::STATUS_OFFSET, 32'h0, rd);
		check(32'(rd[4:0]), 32'(charge_timer_pkg::ST_SELF));
		check(32'(irq), 32'h0000_0001);
		far.setMains(1'b1);
	endtask

	// A supply ramp restarts a fresh charge cycle
	task automatic testSupplyRamp();
		logic [31:0] rd;
		@(posedge core_clk);
		supplyRampUp <= 1'b1;
		@(posedge core_clk);
		supplyRampUp <= 1'b0;
		repeat (6) @(posedge core_clk);
		busXfer(1'b0, charge_timer_pkg::STATUS_OFFSET, 32'h0, rd);
		check(32'(rd[4:0]), 32'(charge_timer_pkg::ST_CHARGE));
		check(32'(rd[5]), 32'h0000_0000);
		check(32'(rd[25:16]), 32'h0000_0000);
	endtask

	task automatic give_verdict();
		$display("errors %0d comparisons %0d", numErrors, comparisons);
		if (numErrors == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Whole sequence needs about 9400 cycles
	initial
	begin
		repeat (40000) @(posedge core_clk);
		numErrors++;
		give_verdict();
	end

	initial
	begin
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (5) @(posedge core_clk);
		testResetValues();
		testChargeLed();
		testScanReadout();
		testDischargeRequest();
		testAlarmPulses();
		testSupplyRamp();
		give_verdict();
	end
endmodule
